// >>> hw/channel_config_offset_regs.v
/*
  Channel-1 configuration and offset calibration registers on an APB slave,
  with the decoded controls driven out to the converter datapath.
  Assumes an APB master on pclk; answers with zero wait states.
*/
// Register access over APB was chosen for this implementation.
// Summary of operation
// RULE1: Config bits 15:6 are a signed phase delay in modulator clock cycles.
// RULE2: Config bit 2 clear follows global filter setting; set bypasses this channel.
// RULE3: Config bits 1:0 select differential pair, shorted, positive or negative test.
// RULE4: High offset register holds bits 23:8 of the signed 24-bit offset.
// RULE5: Low offset register bits 15:8 hold offset bits 7:0.
// RULE6: Config register at 0x0E resets to all zeros.
// RULE7: Offset registers at 0x0F and 0x10 reset to zero.
// RULE8: A global four-bit filter setting governs channels whose bypass is clear.
// RULE9: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "chan_cfg_consts.vh"
module channel_config_offset_regs (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Decoded channel controls
  output reg [9:0] channel_phase_delay,
  output reg channel_dc_block_bypass,
  output reg [3:0] channel_dc_block_effective,
  output reg [1:0] channel_input_select,
  output reg shorted_inputs,
  output reg pos_test_select,
  output reg neg_test_select,
  output reg [23:0] offset_correction
);

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Index table of the stored entries, entry 0 in the low slice
  localparam ENTRIES = 3;
  localparam [29:0] entry_index = {
    {2'h0, `IDX_CHANNEL1_OFFSET_LOW},
    {2'h0, `IDX_CHANNEL1_OFFSET_HIGH},
    {2'h0, `IDX_CHANNEL1_CONFIG}
  };

  wire setup = psel && !penable;
  wire aligned = (paddr[1:0] == 2'h0);
  wire [9:0] index = paddr[11:2];
  wire [2:0] entry_hit;
  wire hit_cfg = entry_hit[0];
  wire hit_high = entry_hit[1];
  wire hit_low = entry_hit[2];
  wire hit_glob = aligned && (index == {2'h0, `IDX_GLOBAL_DC_BLOCK});
  wire mapped = hit_cfg || hit_high || hit_low || hit_glob;
  wire write_now = psel && penable && pready && pwrite && mapped;
  // Only the low two byte lanes carry register data
  wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  wire [15:0] cfg_value;
  wire [15:0] high_value;
  wire [15:0] low_value;
  reg [3:0] global_dc_block_setting;

  function [15:0] merge;
    input [15:0] old_value;
    input [15:0] new_value;
    input [15:0] lanes;
    begin
      merge = (new_value & lanes) | (old_value & ~lanes);
    end
  endfunction

  localparam [47:0] entry_reset = {
    `RST_CHANNEL1_OFFSET_LOW,
    `RST_CHANNEL1_OFFSET_HIGH,
    `RST_CHANNEL1_CONFIG
  };
  localparam [47:0] entry_mask = {
    `MASK_CHANNEL1_OFFSET_LOW,
    `MASK_CHANNEL1_OFFSET_HIGH,
    `MASK_CHANNEL1_CONFIG
  };

  wire [47:0] entry_value;
  genvar e;

  // Entry 0 config, 1 offset high, 2 offset low; one masked register each
  generate
    for (e = 0; e < ENTRIES; e = e + 1) begin : g_entry
      assign entry_hit[e] = aligned && (index == entry_index[e * 10 +: 10]);
      masked_reg16 #(
        .reset_value(entry_reset[e * 16 +: 16]), // RULE6 RULE7
        .write_mask(entry_mask[e * 16 +: 16]) // RULE9
      ) u_entry (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .write_strobe(write_now && entry_hit[e]),
        .write_data(merge(entry_value[e * 16 +: 16], pwdata[15:0], lane_mask)),
        .value(entry_value[e * 16 +: 16])
      );
    end
  endgenerate

  assign cfg_value = entry_value[15:0];
  assign high_value = entry_value[31:16];
  assign low_value = entry_value[47:32];

  // Shared filter setting for every channel, bits 3:0 only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_dc_block_setting <= `RST_GLOBAL_DC_BLOCK;
    end else if (clk_en && write_now && hit_glob && pstrb[0]) begin
      global_dc_block_setting <= pwdata[3:0]; // RULE8
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB answer: wait-state free, read data in the access phase

  // Answer one cycle after the setup edge, error flag with it
  wire next_ready = setup;
  wire next_slverr = setup && !mapped;
  reg [15:0] next_rdata;

  always @* begin
    next_rdata = 16'h0000;
    if (hit_cfg) begin
      next_rdata = cfg_value; // RULE9
    end else if (hit_high) begin
      next_rdata = high_value;
    end else if (hit_low) begin
      next_rdata = low_value; // RULE9
    end else if (hit_glob) begin
      next_rdata = {12'h000, global_dc_block_setting};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= next_ready;
      pslverr <= next_slverr;
      if (setup && !pwrite) begin
        prdata <= {16'h0000, next_rdata};
      end else if (!psel) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded controls, registered one cycle after the stored value

  reg [3:0] next_effective;
  reg next_shorted;
  reg next_pos_test;
  reg next_neg_test;
  wire [1:0] stored_select = cfg_value[`CFG_SEL_HI:`CFG_SEL_LO];
  wire [23:0] next_offset = {high_value, low_value[15:8]};

  always @* begin
    if (cfg_value[`CFG_BYPASS_BIT]) begin
      next_effective = 4'h0; // RULE2
    end else begin
      next_effective = global_dc_block_setting; // RULE8
    end
  end

  // Route flags for the input multiplexer; own pair when none is set
  always @* begin
    next_shorted = 1'b0;
    next_pos_test = 1'b0;
    next_neg_test = 1'b0;
    case (stored_select)
      `SEL_SHORTED: begin
        next_shorted = 1'b1; // RULE3
      end
      `SEL_POS_TEST: begin
        next_pos_test = 1'b1; // RULE3
      end
      `SEL_NEG_TEST: begin
        next_neg_test = 1'b1; // RULE3
      end
      default: begin
        next_shorted = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_phase_delay <= 10'h000;
      channel_dc_block_bypass <= 1'b0;
      channel_dc_block_effective <= 4'h0;
      channel_input_select <= `SEL_DIFFERENTIAL;
      shorted_inputs <= 1'b0;
      pos_test_select <= 1'b0;
      neg_test_select <= 1'b0;
      offset_correction <= 24'h000000;
    end else if (clk_en) begin
      channel_phase_delay <= cfg_value[`CFG_PHASE_HI:`CFG_PHASE_LO]; // RULE1
      channel_dc_block_bypass <= cfg_value[`CFG_BYPASS_BIT]; // RULE2
      channel_dc_block_effective <= next_effective;
      channel_input_select <= stored_select; // RULE3
      shorted_inputs <= next_shorted;
      pos_test_select <= next_pos_test;
      neg_test_select <= next_neg_test;
      offset_correction <= next_offset; // RULE4 RULE5
    end
  end

endmodule

// >>> include/chan_cfg_consts.vh
/*
  Constants for the channel-1 configuration and offset register bank:
  register indexes, field positions, reset values and the global setting
  register that this bank adds. Assumes inclusion by bare name.
*/
`ifndef CHAN_CFG_CONSTS_VH
`define CHAN_CFG_CONSTS_VH

// Register indexes as printed; byte address is four times the index
`define IDX_CHANNEL1_CONFIG 8'h0e
`define IDX_CHANNEL1_OFFSET_HIGH 8'h0f
`define IDX_CHANNEL1_OFFSET_LOW 8'h10
`define IDX_GLOBAL_DC_BLOCK 8'h20

// Reset values
`define RST_CHANNEL1_CONFIG 16'h0000
`define RST_CHANNEL1_OFFSET_HIGH 16'h0000
`define RST_CHANNEL1_OFFSET_LOW 16'h0000
`define RST_GLOBAL_DC_BLOCK 4'h0

// Field positions of the configuration register
`define CFG_PHASE_HI 15
`define CFG_PHASE_LO 6
`define CFG_BYPASS_BIT 2
`define CFG_SEL_HI 1
`define CFG_SEL_LO 0

// Writable-bit masks; other bits are reserved and read as zero
`define MASK_CHANNEL1_CONFIG 16'hffc7
`define MASK_CHANNEL1_OFFSET_HIGH 16'hffff
`define MASK_CHANNEL1_OFFSET_LOW 16'hff00

// Input selection codes
`define SEL_DIFFERENTIAL 2'h0
`define SEL_SHORTED 2'h1
`define SEL_POS_TEST 2'h2
`define SEL_NEG_TEST 2'h3

`endif

// >>> hw/masked_reg16.v
/*
  One 16-bit software register with a writable-bit mask.
  Assumes a synchronous write strobe on pclk; reserved bits stay zero.
*/
`timescale 1ns/1ps
module masked_reg16 #(
  parameter [15:0] reset_value = 16'h0000,
  parameter [15:0] write_mask = 16'hffff
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // Write side
  input wire write_strobe,
  input wire [15:0] write_data,
  // Stored value
  output reg [15:0] value
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= reset_value & write_mask;
    end else if (clk_en && write_strobe) begin
      value <= write_data & write_mask;
    end
  end

endmodule

// >>> testbench/cfg_regs_monitor.sv
/* Checker for the channel register bank; bound to its top by port name. */
`timescale 1ns/1ps
module cfg_regs_monitor (
  // Clock, reset, APB
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Channel controls
  input wire [9:0] channel_phase_delay,
  input wire channel_dc_block_bypass,
  input wire [3:0] channel_dc_block_effective,
  input wire [1:0] channel_input_select,
  input wire shorted_inputs,
  input wire [23:0] offset_correction
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = psel && penable && pready && !pwrite && !pslverr;
  property p_ans; psel && !penable && clk_en |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_r1; rd && paddr == 12'h038 |-> prdata[15:6] == channel_phase_delay; endproperty
  a_r1: assert property (p_r1) else $error("bad phase");
  property p_r2; channel_dc_block_bypass |-> channel_dc_block_effective == 4'h0; endproperty
  a_r2: assert property (p_r2) else $error("bad bypass");
  property p_r3; shorted_inputs == (channel_input_select == 2'h1); endproperty
  a_r3: assert property (p_r3) else $error("bad select");
  property p_r4; rd && paddr == 12'h03c |-> prdata[15:0] == offset_correction[23:8]; endproperty
  a_r4: assert property (p_r4) else $error("bad offset high");
  property p_r5; rd && paddr == 12'h040 |-> prdata[15:8] == offset_correction[7:0]; endproperty
  a_r5: assert property (p_r5) else $error("bad offset low");
  property p_r6; !$past(presetn) |-> channel_phase_delay == 10'h0 && offset_correction == 24'h0;
  endproperty
  a_r6: assert property (p_r6) else $error("bad reset");
  property p_r9; rd |-> prdata[31:16] == 16'h0 && (paddr != 12'h040 || prdata[7:0] == 8'h0);
  endproperty
  a_r9: assert property (p_r9) else $error("reserved set");
  cover property (rd && paddr == 12'h038);
  cover property (channel_dc_block_bypass);
  cover property (pslverr);
endmodule
bind channel_config_offset_regs cfg_regs_monitor cfg_regs_monitor_i (.*);

// >>> testbench/apb_host.sv
/* Host APB master model; xfer is called from one process only. */
`timescale 1ns/1ps
module apb_host (
  // Clock and answer
  input wire pclk,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Request
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  output logic [3:0] pstrb = 4'hf
);
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, input logic [3:0] b = 4'hf);
    @(posedge pclk);
    psel <= 1'b1;
    pstrb <= b;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

// >>> testbench/channel_config_offset_regs_tb.sv
/* Bench for the channel register bank; needs the host model and checker. */
`timescale 1ns/1ps
module channel_config_offset_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  wire psel, penable, pwrite, pready, pslverr, channel_dc_block_bypass;
  wire shorted_inputs, pos_test_select, neg_test_select;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] pstrb, channel_dc_block_effective;
  wire [9:0] channel_phase_delay;
  wire [1:0] channel_input_select;
  wire [23:0] offset_correction;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  integer seed = 32'hf8f0c30d;
  logic [31:0] rnd;
  logic [11:0] adr [0:5] = '{12'h038, 12'h03c, 12'h040, 12'h080, 12'h044, 12'h03a};
  logic [15:0] mk [0:5] = '{16'hffc7, 16'hffff, 16'hff00, 16'h000f, 16'h0, 16'h0};
  logic [15:0] m [0:5] = '{default: 16'h0};
  always #10 pclk = ~pclk;
  apb_host apb_host_i (.*);
  channel_config_offset_regs channel_config_offset_regs_i (.*);
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask
  task op(input int j, input logic w, input logic [31:0] d, input logic [3:0] b = 4'hf);
    logic [31:0] q;
    logic e;
    logic [15:0] ln;
    ln = {{8{b[1]}}, {8{b[0]}}};
    apb_host_i.xfer(w, adr[j], d, q, e, b);
    chk("error flag", mk[j] == 16'h0, e);
    if (w) m[j] = ((d[15:0] & ln) | (m[j] & ~ln)) & mk[j];
    else chk("read data", m[j], q);
  endtask
  task outs;
    repeat (2) @(posedge pclk);
    #1;
    chk("controls", {m[0][15:6], m[0][2], m[0][2] ? 4'h0 : m[3][3:0], m[0][1:0],
      m[0][1:0] == 2'h3, m[0][1:0] == 2'h2, m[0][1:0] == 2'h1}, {channel_phase_delay,
      channel_dc_block_bypass, channel_dc_block_effective, channel_input_select,
      neg_test_select, pos_test_select, shorted_inputs});
    chk("offset", {m[1], m[2][15:8]}, offset_correction);
  endtask
  task frozen(input logic [31:0] d);
    logic [23:0] was;
    was = {m[1], m[2][15:8]};
    op(1, 1'b1, d);
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk("frozen offset", was, offset_correction);
    @(posedge pclk);
    clk_en <= 1'b1;
    outs;
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int j = 0; j < 6; j++) op(j, 1'b0, 32'h0);
    outs;
    for (int s = 0; s < 4; s++) begin
      op(0, 1'b1, 32'hfffffffc | s);
      outs;
    end
    for (int k = 0; k < 60; k++) begin
      rnd = $random(seed);
      op({$random(seed)} % 6, k % 3 != 2, $random(seed), rnd[3:0]);
      outs;
    end
    frozen({16'h0, ~m[1]});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    m = '{default: 16'h0};
    for (int j = 0; j < 6; j++) op(j, 1'b0, 32'h0);
    outs;
    tally_and_finish;
  end
endmodule
